// ---- verilog/fsu_defines.svh ----
`ifndef FSU_DEFINES_SVH
`define FSU_DEFINES_SVH

// Field widths.
`define FSU_SR_W        8
`define FSU_CNT_W       4

// Counter value that wraps to zero on the next count.
`define FSU_CNT_MAX     4'hF

// Clock source select values: {clock_source_select_hi, ext_edge_select}.
`define FSU_SRC_SW      2'h0
`define FSU_SRC_TIMER   2'h1

// Status byte field positions.
`define FSU_ST_START    7
`define FSU_ST_OVF      6

// Reset values.
`define FSU_CTRL_RST    8'h00
`define FSU_SR_RST      8'h00
`define FSU_CNT_RST     4'h0

`endif

// ---- verilog/fsu_pkg.sv ----
package fsu_pkg;

  typedef enum logic [1:0] {
    FSU_WIRE_OFF,
    FSU_WIRE_THREE,
    FSU_WIRE_TWO,
    FSU_WIRE_TWO_HOLD
  } fsu_wire_type;

  // Control byte, most significant field first.
  typedef struct packed {
    logic         start_ie;
    logic         ovf_ie;
    fsu_wire_type wire_mode;
    logic         clock_source_select_hi;
    logic         ext_edge_select;
    logic         shift_clock_strobe;
    logic         clock_toggle_strobe;
  } fsu_ctrl_type;

  typedef struct packed {
    logic       start_flag;
    logic       counter_overflow_flag;
    logic [1:0] rsvd;
    logic [3:0] count;
  } fsu_status_type;

endpackage

// ---- verilog/fsu_flex_serial.sv ----
// Functional notes
// - One 8-bit shift register; its MSB feeds the output pin of the wire mode.
// - Output passes a latch so it changes on the edge opposite to sampling.
// - Serial input is always taken from the data-input pin.
// - The 4-bit counter is readable, writable and flags overflow.
// - Shift register and counter advance on the same clock for timer and software sources.
// - With an external clock the counter counts both serial clock edges, or toggle strobes when the stored clock strobe bit is set.
// - Three clock sources: serial clock pin, timer compare, software strobe.
// - Two-wire mode flags a detected start condition for an interrupt.
// - Two-wire mode holds the clock low after start; the hold variant also after overflow.
// - Three-wire mode fits SPI modes 0 and 1; no hardware slave select.
// - Two linked units swap their full registers after eight clock periods.
// - Edge select 0: sample on rising edges, change output on falling.
// - Edge select 1: sample on falling edges, change output on rising.
// - Data loaded and counter cleared half a clock before the first sample.
// - Eight pulses give sixteen edges, overflow the counter, end the byte.
// - The overflow request can wake the processor from idle.
// - Status write with overflow bit set clears it and loads the count.
// - Toggle strobe flips the clock pin and, if selected, counts once.
// - Master runs at half the system clock by alternating control writes.
// - A write that meets a shift keeps the written value, no shift.
// - A shift moves toward the MSB, input entering at the LSB.
`timescale 1ns/1ps
`default_nettype none
`include "fsu_defines.svh"

module fsu_flex_serial
  import fsu_pkg::*;
(
  // System clock and reset.
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  // Serial clock pin, the clock of the link-facing logic.
  input  wire logic                  serial_clock_pin,
  // Serial data and two-wire data pins.
  input  wire logic                  serial_in_pin,
  input  wire logic                  sda_in,
  // Pin drive enables set by the port direction logic.
  input  wire logic                  clk_drive_en,
  input  wire logic                  data_drive_en,
  // Timer compare match pulse.
  input  wire logic                  timer_match,
  // Register writes.
  input  wire logic                  ctrl_wr_en,
  input  wire fsu_ctrl_type          ctrl_wr_data,
  input  wire logic                  sr_wr_en,
  input  wire logic [`FSU_SR_W-1:0]  sr_wr_data,
  input  wire logic                  status_wr_en,
  input  wire fsu_status_type        status_wr_data,
  // Register read-back.
  output fsu_ctrl_type               serial_control_reg,
  output logic [`FSU_SR_W-1:0]       serial_shift_reg,
  output fsu_status_type             serial_status_reg,
  // Interrupt requests.
  output logic                       ovf_irq_q,
  output logic                       start_irq_q,
  // Pin drivers.
  output logic                       data_out_q,
  output logic                       data_oe_q,
  output logic                       sda_out_q,
  output logic                       sda_oe_q,
  output logic                       clk_out_q,
  output logic                       clk_oe_q
);

  // Link domain reset, synchronised to the serial clock.
  logic lrst_s1_q;
  logic lrst_q;
  // Edge toggles and data captured at each edge.
  logic rise_tgl_q;
  logic fall_tgl_q;
  logic rise_bit_q;
  logic fall_bit_q;

  always_ff @(posedge serial_clock_pin) begin
    lrst_s1_q <= sys_rst;
    lrst_q    <= lrst_s1_q;
  end

  // The pin is sampled right at each edge, so no sync stage is lost here.
  always_ff @(posedge serial_clock_pin) begin
    if (lrst_q) begin
      rise_tgl_q <= 1'b0;
      rise_bit_q <= 1'b0;
    end else begin
      rise_tgl_q <= ~rise_tgl_q;
      rise_bit_q <= serial_in_pin;
    end
  end

  always_ff @(negedge serial_clock_pin) begin
    if (lrst_q) begin
      fall_tgl_q <= 1'b0;
      fall_bit_q <= 1'b0;
    end else begin
      fall_tgl_q <= ~fall_tgl_q;
      fall_bit_q <= serial_in_pin;
    end
  end

  // Toggle synchronisers; only the second stage onward is decoded.
  logic [2:0] rise_s_q;
  logic [2:0] fall_s_q;
  logic [1:0] di_s_q;
  logic [2:0] sda_s_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rise_s_q <= 3'h0;
      fall_s_q <= 3'h0;
      di_s_q   <= 2'h0;
      sda_s_q  <= 3'h7;
    end else begin
      rise_s_q <= {rise_s_q[1:0], rise_tgl_q};
      fall_s_q <= {fall_s_q[1:0], fall_tgl_q};
      di_s_q   <= {di_s_q[0], serial_in_pin};
      sda_s_q  <= {sda_s_q[1:0], sda_in};
    end
  end

  // The captured bits are read several cycles after their edge, while
  // stable; a serial clock faster than about a quarter of clk_sys breaks
  // this.
  logic rise_ev;
  logic fall_ev;
  logic sda_fall;
  assign rise_ev  = rise_s_q[2] ^ rise_s_q[1];
  assign fall_ev  = fall_s_q[2] ^ fall_s_q[1];
  assign sda_fall = sda_s_q[2] & ~sda_s_q[1];
  fsu_ctrl_type   ctrl_q;
  logic [`FSU_SR_W-1:0]  sr_q;
  logic [`FSU_CNT_W-1:0] cnt_q;
  logic           ovf_q;
  logic           start_q;
  logic           scl_high_q;
  logic           latch_q;
  logic           tgl_level_q;
  // Strobe bits clock only in the cycle of a control write; the stored clock strobe bit also picks the external count source.
  logic ctrl_strb_clk;
  logic ctrl_strb_tgl;
  assign ctrl_strb_clk = ctrl_wr_en & ctrl_wr_data.shift_clock_strobe;
  assign ctrl_strb_tgl = ctrl_wr_en & ctrl_wr_data.clock_toggle_strobe;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q <= fsu_ctrl_type'(`FSU_CTRL_RST);
    end else if (ctrl_wr_en) begin
      ctrl_q <= ctrl_wr_data;
    end
  end

  logic ext_src;
  logic edge_sel;
  logic two_wire;
  assign ext_src  = ctrl_q.clock_source_select_hi;
  assign edge_sel = ctrl_q.ext_edge_select;
  assign two_wire = ctrl_q.wire_mode == FSU_WIRE_TWO ||
                    ctrl_q.wire_mode == FSU_WIRE_TWO_HOLD;
  // Clock source decode.
  logic shift_ev;
  logic cnt_ev;
  logic din_bit;
  always_comb begin
    if (ext_src) begin
      shift_ev = edge_sel ? fall_ev : rise_ev;
      din_bit  = edge_sel ? fall_bit_q : rise_bit_q;
      if (ctrl_q.shift_clock_strobe) begin
        cnt_ev = ctrl_strb_tgl;
      end else begin
        cnt_ev = rise_ev | fall_ev;
      end
    end else if (edge_sel) begin
      shift_ev = timer_match;
      din_bit  = di_s_q[1];
      cnt_ev   = timer_match;
    end else begin
      shift_ev = ctrl_strb_clk;
      din_bit  = di_s_q[1];
      cnt_ev   = ctrl_strb_clk;
    end
  end

  // A write wins over a coincident shift.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sr_q <= `FSU_SR_RST;
    end else if (sr_wr_en) begin
      sr_q <= sr_wr_data;
    end else if (shift_ev) begin
      sr_q <= {sr_q[`FSU_SR_W-2:0], din_bit};
    end
  end

  function automatic logic [`FSU_CNT_W-1:0] cnt_inc(
    input logic [`FSU_CNT_W-1:0] v
  );
    cnt_inc = v + `FSU_CNT_W'(1);
  endfunction
  logic wrap;
  logic ovf_clr;
  logic ovf_d;
  logic start_set;
  logic start_clr;
  logic start_d;
  assign wrap = cnt_ev & ~status_wr_en & (cnt_q == `FSU_CNT_MAX);
  assign ovf_clr = status_wr_en & status_wr_data.counter_overflow_flag;
  assign ovf_d = (ovf_q & ~ovf_clr) | wrap;
  assign start_set = two_wire & sda_fall & scl_high_q;
  assign start_clr = status_wr_en & status_wr_data.start_flag;
  assign start_d = (start_q & ~start_clr) | start_set;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= `FSU_CNT_RST;
    end else if (status_wr_en) begin
      cnt_q <= status_wr_data.count;
    end else if (cnt_ev) begin
      cnt_q <= cnt_inc(cnt_q);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ovf_q   <= 1'b0;
      start_q <= 1'b0;
    end else begin
      ovf_q   <= ovf_d;
      start_q <= start_d;
    end
  end

  // Pin level as seen through the edge events.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scl_high_q <= 1'b0;
    end else if (rise_ev) begin
      scl_high_q <= 1'b1;
    end else if (fall_ev) begin
      scl_high_q <= 1'b0;
    end
  end

  // The latch is open only during the clock phase that precedes a sampling
  // edge, so the output moves on the opposite edge. Internal sources keep
  // it open, since no pin edge is involved.
  logic latch_open;
  logic latch_d;
  assign latch_open = ~ext_src | (scl_high_q == edge_sel);
  assign latch_d = latch_open ? sr_q[`FSU_SR_W-1] : latch_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tgl_level_q <= 1'b0;
    end else if (ctrl_strb_tgl) begin
      tgl_level_q <= ~tgl_level_q;
    end
  end

  // Requests are built from next values so they line up with the flags.
  fsu_ctrl_type ctrl_d;
  assign ctrl_d = ctrl_wr_en ? ctrl_wr_data : ctrl_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ovf_irq_q   <= 1'b0;
      start_irq_q <= 1'b0;
    end else begin
      ovf_irq_q   <= ovf_d & ctrl_d.ovf_ie;
      start_irq_q <= start_d & ctrl_d.start_ie;
    end
  end

  // Pins. Three-wire mode has no select pin; software handles selection.
  logic hold_d;
  assign hold_d = (two_wire & start_d) |
                  (ctrl_q.wire_mode == FSU_WIRE_TWO_HOLD & ovf_d);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      data_out_q <= 1'b0;
      data_oe_q  <= 1'b0;
      sda_out_q  <= 1'b0;
      sda_oe_q   <= 1'b0;
      clk_out_q  <= 1'b0;
      clk_oe_q   <= 1'b0;
    end else begin
      data_out_q <= latch_d;
      data_oe_q  <= data_drive_en & ctrl_q.wire_mode == FSU_WIRE_THREE;
      sda_out_q  <= 1'b0;
      sda_oe_q   <= two_wire & ~latch_d;
      clk_out_q  <= tgl_level_q & ~hold_d;
      clk_oe_q   <= hold_d | (clk_drive_en & ~two_wire);
    end
  end

  assign serial_control_reg = ctrl_q;
  assign serial_shift_reg   = sr_q;
  assign serial_status_reg  = '{start_flag: start_q,
                                counter_overflow_flag: ovf_q,
                                rsvd: 2'h0,
                                count: cnt_q};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_start_seen;
    start_set ##1 (start_q && two_wire && !start_clr);
  endsequence

  a_shift_left: assert property (
    shift_ev && !sr_wr_en |=>
      sr_q == {$past(sr_q[`FSU_SR_W-2:0]), $past(din_bit)})
    else $error("shift did not move left with input at bit 0");
  a_write_wins: assert property (
    sr_wr_en && shift_ev |=> sr_q == $past(sr_wr_data))
    else $error("write lost against a shift");
  a_rise_sample: assert property (
    ext_src && !edge_sel && rise_ev && !sr_wr_en |=>
      sr_q[0] == $past(rise_bit_q))
    else $error("rising edge sample not shifted in");
  a_fall_sample: assert property (
    ext_src && edge_sel && fall_ev && !sr_wr_en |=>
      sr_q[0] == $past(fall_bit_q))
    else $error("falling edge sample not shifted in");
  a_wrap_flags: assert property (
    cnt_ev && !status_wr_en && cnt_q == `FSU_CNT_MAX |=>
      ovf_q && cnt_q == `FSU_CNT_RST)
    else $error("counter wrap did not set overflow");
  a_flag_sticky: assert property (
    ovf_q && !ovf_clr |=> ovf_q)
    else $error("overflow flag dropped without a clear");
  a_status_clear: assert property (
    ovf_clr && !wrap |=> !ovf_q && cnt_q == $past(status_wr_data.count))
    else $error("status write did not clear flag and load count");
  a_ext_both_edges: assert property (
    ext_src && !ctrl_q.shift_clock_strobe && (rise_ev || fall_ev) &&
      !status_wr_en |=> cnt_q == cnt_inc($past(cnt_q)))
    else $error("external edge not counted");
  a_irq_gate: assert property (
    ovf_irq_q |-> ovf_q && ctrl_q.ovf_ie)
    else $error("overflow request without flag and enable");
  a_toggle_pin: assert property (
    ctrl_strb_tgl |=> tgl_level_q != $past(tgl_level_q))
    else $error("toggle strobe did not flip the clock level");
  a_latch_hold: assert property (
    ext_src && scl_high_q != edge_sel && !ctrl_wr_en |=>
      latch_q == $past(latch_q))
    else $error("output moved on the sampling phase");
  a_start_hold: assert property (
    s_start_seen |-> ##1 clk_oe_q && !clk_out_q)
    else $error("clock not held low after start");

endmodule
`default_nettype wire

// ---- testbench/fsu_spi_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// Remote mode 0/1 master. Its clock runs only inside frames, and around
// reset so that the link-side logic of the device clears.
module fsu_spi_partner (
  // Link reset request and data from the device.
  input  wire logic rst,
  input  wire logic miso,
  // Clock and data towards the device.
  output logic      sclk,
  output logic      mosi
);
  localparam realtime HALF = 24.0;
  logic [7:0] got_q;

  task automatic pulse;
    #HALF sclk = 1'b1;
    #HALF sclk = 1'b0;
  endtask

  // Parks the clock line at one level, as a two-wire master does.
  task automatic set_clk_level(input logic v);
    sclk = v;
  endtask

  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    got_q = 8'h00;
    #3;
    while (rst) begin
      pulse();
    end
    repeat (3) pulse();
  end

  // Data leads the sampling edge by half a period in both modes.
  task automatic xfer(input logic mode1, input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      if (mode1) begin
        sclk = 1'b1;
        mosi = tx[i];
        #HALF got_q = {got_q[6:0], miso};
        sclk = 1'b0;
        #HALF;
      end else begin
        mosi = tx[i];
        #HALF got_q = {got_q[6:0], miso};
        sclk = 1'b1;
        #HALF sclk = 1'b0;
      end
    end
    // A released line must not look like a held bit.
    mosi = ~tx[0];
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import fsu_pkg::*;
;
  logic           clk_sys, sys_rst, sclk, mosi, timer_match;
  logic           ctrl_wr_en, sr_wr_en, status_wr_en;
  fsu_ctrl_type   ctrl_wr_data, serial_control_reg;
  fsu_status_type status_wr_data, serial_status_reg;
  logic [7:0]     sr_wr_data, serial_shift_reg;
  logic           ovf_irq_q, data_out_q, data_oe_q, clk_out_q, clk_oe_q;
  logic           sda, start_irq;
  int             bad_count = 0;
  int             cmp_count = 0;

  fsu_flex_serial DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .serial_clock_pin(sclk),
    .serial_in_pin(mosi), .sda_in(sda), .clk_drive_en(1'b1),
    .data_drive_en(1'b1), .timer_match(timer_match),
    .ctrl_wr_en(ctrl_wr_en), .ctrl_wr_data(ctrl_wr_data),
    .sr_wr_en(sr_wr_en), .sr_wr_data(sr_wr_data),
    .status_wr_en(status_wr_en), .status_wr_data(status_wr_data),
    .serial_control_reg(serial_control_reg),
    .serial_shift_reg(serial_shift_reg),
    .serial_status_reg(serial_status_reg), .ovf_irq_q(ovf_irq_q),
    .start_irq_q(start_irq), .data_out_q(data_out_q), .data_oe_q(data_oe_q),
    .sda_out_q(), .sda_oe_q(), .clk_out_q(clk_out_q), .clk_oe_q(clk_oe_q)
  );

  fsu_spi_partner far (
    .rst(sys_rst), .miso(data_out_q), .sclk(sclk), .mosi(mosi)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic give_verdict;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic fsu_ctrl_type mk(input logic ie, input logic hi,
                                      input logic es, input logic st,
                                      input logic tg);
    mk = '{1'b0, ie, FSU_WIRE_THREE, hi, es, st, tg};
  endfunction

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr_ctrl(input fsu_ctrl_type c);
    @(posedge clk_sys);
    ctrl_wr_en <= 1'b1;
    ctrl_wr_data <= c;
    @(posedge clk_sys);
    ctrl_wr_en <= 1'b0;
  endtask

  task automatic wr_sr(input logic [7:0] v);
    @(posedge clk_sys);
    sr_wr_en <= 1'b1;
    sr_wr_data <= v;
    @(posedge clk_sys);
    sr_wr_en <= 1'b0;
  endtask

  task automatic wr_st(input logic [7:0] v);
    @(posedge clk_sys);
    status_wr_en <= 1'b1;
    status_wr_data <= v;
    @(posedge clk_sys);
    status_wr_en <= 1'b0;
  endtask

  // Back-to-back control writes, alternating two values.
  task automatic ctrl_burst(input fsu_ctrl_type a, input fsu_ctrl_type b);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      ctrl_wr_en <= 1'b1;
      ctrl_wr_data <= i[0] ? b : a;
    end
    @(posedge clk_sys);
    ctrl_wr_en <= 1'b0;
  endtask

  task automatic t_reset;
    chk("control", 8'h00, serial_control_reg);
    chk("shift", 8'h00, serial_shift_reg);
    chk("status", 8'h00, serial_status_reg);
    chk("ovf_irq_q", 8'h00, 8'(ovf_irq_q));
  endtask

  task automatic t_toggle;
    wr_ctrl(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
    settle(3);
    chk("control", 8'h11, serial_control_reg);
    chk("clk_out_q", 8'h01, 8'(clk_out_q));
  endtask

  task automatic t_count;
    wr_ctrl(mk(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    wr_st(8'h4F);
    @(posedge clk_sys);
    timer_match <= 1'b1;
    @(posedge clk_sys);
    timer_match <= 1'b0;
    settle(4);
    chk("status", 8'h40, serial_status_reg);
    chk("ovf_irq_q", 8'h01, 8'(ovf_irq_q));
    settle(4);
    chk("status", 8'h40, serial_status_reg);
    wr_st(8'h45);
    settle(2);
    chk("status", 8'h05, serial_status_reg);
    chk("ovf_irq_q", 8'h00, 8'(ovf_irq_q));
    wr_st(8'h0F);
    // The strobe is decoded with the stored source, so select it first.
    wr_ctrl(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    wr_ctrl(mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0));
    settle(3);
    chk("status", 8'h40, serial_status_reg);
    chk("ovf_irq_q", 8'h00, 8'(ovf_irq_q));
  endtask

  task automatic t_collide;
    @(posedge clk_sys);
    sr_wr_en <= 1'b1;
    sr_wr_data <= 8'hC3;
    ctrl_wr_en <= 1'b1;
    ctrl_wr_data <= mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge clk_sys);
    sr_wr_en <= 1'b0;
    ctrl_wr_en <= 1'b0;
    settle(3);
    chk("shift", 8'hC3, serial_shift_reg);
    wr_ctrl(mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0));
    settle(4);
    chk("shift", 8'h86, serial_shift_reg);
  endtask

  task automatic t_link(input logic es, input logic [7:0] dev,
                        input logic [7:0] rem);
    wr_ctrl(mk(1'b1, 1'b1, es, 1'b0, 1'b0));
    wr_sr(dev);
    wr_st(8'h40);
    settle(2);
    chk("data_oe_q", 8'h01, 8'(data_oe_q));
    far.xfer(es, rem);
    for (int k = 0; k < 40; k++) begin
      if (serial_status_reg.counter_overflow_flag === 1'b1) break;
      @(posedge clk_sys);
    end
    settle(1);
    chk("shift", rem, serial_shift_reg);
    chk("far data", dev, far.got_q);
    chk("status", 8'h40, serial_status_reg);
    chk("ovf_irq_q", 8'h01, 8'(ovf_irq_q));
  endtask

  task automatic t_fast;
    wr_st(8'h40);
    wr_sr(8'h5A);
    ctrl_burst(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1),
               mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
    settle(4);
    chk("shift", 8'hFF, serial_shift_reg);
    chk("status", 8'h08, serial_status_reg);
    wr_st(8'h40);
    ctrl_burst(mk(1'b0, 1'b1, 1'b0, 1'b1, 1'b1),
               mk(1'b0, 1'b1, 1'b0, 1'b1, 1'b1));
    settle(4);
    chk("status", 8'h40, serial_status_reg);
    chk("clk_out_q", 8'h01, 8'(clk_out_q));
  endtask

  // Start condition: data falls while the clock line stands high.
  task automatic t_start;
    fsu_ctrl_type c;
    c = mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    c.wire_mode = FSU_WIRE_TWO;
    c.start_ie = 1'b1;
    wr_ctrl(c);
    wr_st(8'h40);
    settle(1);
    far.set_clk_level(1'b1);
    settle(6);
    @(posedge clk_sys);
    sda <= 1'b0;
    settle(6);
    chk("status", 8'h80, serial_status_reg);
    chk("start_irq_q", 8'h01, 8'(start_irq));
    chk("clk_oe_q", 8'h01, 8'(clk_oe_q));
    chk("clk_out_q", 8'h00, 8'(clk_out_q));
    wr_st(8'h80);
    settle(2);
    chk("status", 8'h00, serial_status_reg);
    chk("start_irq_q", 8'h00, 8'(start_irq));
    chk("clk_oe_q", 8'h00, 8'(clk_oe_q));
    @(posedge clk_sys);
    sda <= 1'b1;
    settle(2);
    far.set_clk_level(1'b0);
    settle(4);
  endtask

  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    timer_match = 1'b0;
    sda = 1'b1;
    ctrl_wr_en = 1'b0;
    sr_wr_en = 1'b0;
    status_wr_en = 1'b0;
    ctrl_wr_data = 8'h00;
    sr_wr_data = 8'h00;
    status_wr_data = 8'h00;
    // Held long enough for three link clock rises to clear the link side.
    repeat (48) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle(1);
    t_reset();
    t_toggle();
    t_count();
    t_collide();
    repeat (40) @(posedge clk_sys);
    t_link(1'b0, 8'hA5, 8'h3C);
    t_link(1'b1, 8'h69, 8'h96);
    t_fast();
    t_start();
    give_verdict();
  end
endmodule
`default_nettype wire
